/* File: verilog/rcs_pkg.sv */
/*
 * rcs_pkg: constants and carriers for the run command source selector.
 * assumes one control clock; all settings arrive as plain ports.
 */
package rcs_pkg;
    // ==========================================================
    // run source selection codes
    localparam logic [7:0] SRC_TERMINAL = 8'h01;
    localparam logic [7:0] SRC_KEYPAD   = 8'h02;
    localparam logic [7:0] SRC_SERIAL   = 8'h03;
    localparam logic [7:0] SRC_OPTION   = 8'h04;
    // ==========================================================
    // stop key enable codes
    localparam logic [7:0] STOPKEY_ALWAYS    = 8'h00;
    localparam logic [7:0] STOPKEY_DISABLE   = 8'h01;
    localparam logic [7:0] STOPKEY_TRIP_ONLY = 8'h02;
    // ==========================================================
    // input terminal function codes
    localparam logic [7:0] FN_FORWARD   = 8'h00;
    localparam logic [7:0] FN_REVERSE   = 8'h01;
    localparam logic [7:0] FN_STA       = 8'h14;
    localparam logic [7:0] FN_STP       = 8'h15;
    localparam logic [7:0] FN_DIR3      = 8'h16;
    localparam logic [7:0] FN_KEY_OVR   = 8'h1f;
    localparam logic [7:0] FN_TERM_OVR  = 8'h33;
    localparam int         NUM_TERMINALS = 7;
    // ==========================================================
    // frequency source selection reported while overridden
    localparam logic [1:0] FREQ_CONFIGURED = 2'h0;
    localparam logic [1:0] FREQ_KEYPAD     = 2'h1;
    localparam logic [1:0] FREQ_TERMINAL   = 2'h2;

    // a run request from one source
    typedef struct packed {
        logic run;
        logic reverse;
    } rcs_cmd_t;

    typedef enum logic [2:0] {
        ST_STOPPED = 3'b001,
        ST_RUNNING = 3'b010,
        ST_LOCKED  = 3'b100
    } rcs_state_t;
endpackage

/* File: verilog/rcs_run_select.sv */
/*
 * rcs_run_select: picks the run/stop command source and drives the run command.
 * assumes terminal pins and keypad keys are asynchronous; other inputs are
 * from logic on sys_clk.
 */
//
// Function
// - source code 04 takes run/stop from the option board only
// - run starts only with a valid frequency command present
// - keypad override input on: keypad keys control run and stop
// - terminal override input on: terminals control run and stop
// - override also switches frequency source to keypad or terminal analog
// - override change while running stops; restart needs run off then on
// - both overrides on: keypad override wins
// - source 01 terminals, 02 keypad, 03 serial bus
// - stop key setting 00: keypad stop stops any source, or only clears the trip while tripped
// - stop key setting 01: stop key ignored unless source is keypad
// - stop key setting 02: stop key only clears a trip unless source is keypad
// - after keypad stop of external run, restart needs run off then on
// - functions not assigned to any terminal read as off
// - forward and reverse terminals both on means stop
`timescale 1ns/10ps
`default_nettype none
module rcs_run_select
    import rcs_pkg::*;
#(
    parameter int NTERM = NUM_TERMINALS
) (
    input  wire logic             sys_clk,                // control clock
    input  wire logic             reset,                  // synchronous, active high
    input  wire logic [7:0]       run_source_select,      // configured run source
    input  wire logic [7:0]       stop_key_enable,        // stop key policy
    input  wire logic [NTERM*8-1:0] input_function_assign, // function code per terminal
    input  wire logic [NTERM-1:0] terminal_in,            // terminal pins, active high
    input  wire logic             keypad_run_key,         // keypad run key pin
    input  wire logic             keypad_stop_key,        // keypad stop/reset key pin
    input  wire rcs_cmd_t         serial_cmd,             // serial bus run request
    input  wire rcs_cmd_t         option_cmd,             // option board run request
    input  wire logic             freq_valid,             // frequency command present
    input  wire logic             tripped,                // drive is in trip
    output logic                  run_out,                // run command to drive core
    output logic                  reverse_out,            // direction to drive core
    output logic [1:0]            freq_source_sel,        // frequency source override
    output logic                  trip_clear              // one-cycle trip clear pulse
);
    // ==========================================================
    // pin synchronisers
    logic [NTERM-1:0] term_meta;
    logic [NTERM-1:0] term_sync;
    logic [1:0]       key_meta;
    logic [1:0]       key_sync;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            term_meta <= '0;
            term_sync <= '0;
            key_meta  <= 2'h0;
            key_sync  <= 2'h0;
        end else begin
            term_meta <= terminal_in;
            term_sync <= term_meta;
            // both keys share one pair of stages so run and stop never skew apart
            key_meta  <= {keypad_stop_key, keypad_run_key};
            key_sync  <= key_meta;
        end
    end

    // ==========================================================
    // function decode: an unassigned function stays off
    function automatic logic fn_level(input logic [7:0] code,
                                      input logic [NTERM*8-1:0] assign_v,
                                      input logic [NTERM-1:0] lvl);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < NTERM; i++) begin
            if (assign_v[i*8 +: 8] == code && lvl[i]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    function automatic logic fn_assigned(input logic [7:0] code,
                                         input logic [NTERM*8-1:0] assign_v);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < NTERM; i++) begin
            if (assign_v[i*8 +: 8] == code) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    logic fwd_on;
    logic rev_on;
    logic sta_on;
    logic stp_on;
    logic dir3_on;
    logic three_wire;
    logic key_ovr;
    logic term_ovr;
    always_comb begin
        fwd_on     = fn_level(FN_FORWARD, input_function_assign, term_sync);
        rev_on     = fn_level(FN_REVERSE, input_function_assign, term_sync);
        sta_on     = fn_level(FN_STA, input_function_assign, term_sync);
        // stop is normally closed: assigned and open means stop
        stp_on     = fn_level(FN_STP, input_function_assign, term_sync);
        dir3_on    = fn_level(FN_DIR3, input_function_assign, term_sync);
        three_wire = fn_assigned(FN_STP, input_function_assign);
        key_ovr    = fn_level(FN_KEY_OVR, input_function_assign, term_sync);
        term_ovr   = fn_level(FN_TERM_OVR, input_function_assign, term_sync);
    end

    // ==========================================================
    // three-wire latch: start on rising edge of start while stop closed
    logic sta_prev;
    logic three_run;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sta_prev  <= 1'b0;
            three_run <= 1'b0;
        end else begin
            sta_prev <= sta_on;
            if (!stp_on) begin
                three_run <= 1'b0;
            end else if (sta_on && !sta_prev) begin
                three_run <= 1'b1;
            end
        end
    end

    // keypad run latch: run key starts, stop key stops when keypad rules
    logic key_run_prev;
    logic keypad_run;
    logic key_stop_prev;
    logic stop_press;
    assign stop_press = key_sync[1] && !key_stop_prev;

    // ==========================================================
    // source arbitration
    // serial and option requests are already on sys_clk, so they skip the synchronisers
    typedef enum logic [2:0] {
        SEL_TERM   = 3'b001,
        SEL_KEYPAD = 3'b010,
        SEL_EXT    = 3'b100
    } rcs_sel_t;

    rcs_sel_t  sel;
    rcs_cmd_t  term_cmd;
    rcs_cmd_t  req;
    logic      keypad_rules;
    always_comb begin
        if (three_wire) begin
            term_cmd.run     = three_run;
            term_cmd.reverse = dir3_on;
        end else begin
            term_cmd.run     = fwd_on ^ rev_on;
            term_cmd.reverse = rev_on && !fwd_on;
        end
        if (key_ovr) begin
            sel = SEL_KEYPAD;
        end else if (term_ovr) begin
            sel = SEL_TERM;
        end else if (run_source_select == SRC_KEYPAD) begin
            sel = SEL_KEYPAD;
        end else if (run_source_select == SRC_TERMINAL) begin
            sel = SEL_TERM;
        end else begin
            sel = SEL_EXT;
        end
        keypad_rules = (sel == SEL_KEYPAD);
        case (sel)
            SEL_TERM:   req = term_cmd;
            SEL_KEYPAD: req = '{run: keypad_run, reverse: 1'b0};
            SEL_EXT: begin
                if (run_source_select == SRC_SERIAL) begin
                    req = serial_cmd;
                end else if (run_source_select == SRC_OPTION) begin
                    req = option_cmd;
                end else begin
                    req = '{run: 1'b0, reverse: 1'b0};
                end
            end
            default:    req = '{run: 1'b0, reverse: 1'b0};
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            key_run_prev  <= 1'b0;
            key_stop_prev <= 1'b0;
            keypad_run    <= 1'b0;
        end else begin
            key_run_prev  <= key_sync[0];
            key_stop_prev <= key_sync[1];
            if (!keypad_rules || (stop_press && !tripped)) begin
                keypad_run <= 1'b0;
            end else if (key_sync[0] && !key_run_prev) begin
                keypad_run <= 1'b1;
            end
        end
    end

    // ==========================================================
    // stop key policy for non-keypad sources
    logic ext_stop;
    always_comb begin
        case (stop_key_enable)
            STOPKEY_ALWAYS:    ext_stop = stop_press && !tripped;
            STOPKEY_DISABLE:   ext_stop = 1'b0;
            STOPKEY_TRIP_ONLY: ext_stop = 1'b0;
            default:           ext_stop = 1'b0;
        endcase
        if (keypad_rules) begin
            ext_stop = 1'b0;
        end
    end

    // ==========================================================
    // reset function of the stop key: off the keypad, policy 01 and
    // unknown policies mute the key completely, trip clearing included
    logic key_resets;
    always_comb begin
        case (stop_key_enable)
            STOPKEY_ALWAYS:    key_resets = 1'b1;
            STOPKEY_TRIP_ONLY: key_resets = 1'b1;
            default:           key_resets = 1'b0;
        endcase
        if (keypad_rules) begin
            key_resets = 1'b1;
        end
    end

    // ==========================================================
    // run state: a forced stop locks until run goes off then on
    logic       req_prev;
    logic [1:0] ovr_prev;
    logic       ovr_change;
    rcs_state_t state;
    assign ovr_change = ovr_prev != {key_ovr, term_ovr};

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            req_prev <= 1'b0;
            ovr_prev <= 2'h0;
        end else begin
            req_prev <= req.run;
            ovr_prev <= {key_ovr, term_ovr};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state <= ST_STOPPED;
        end else begin
            case (state)
                ST_STOPPED: begin
                    if (req.run && freq_valid) begin
                        state <= ST_RUNNING;
                    end
                end
                ST_RUNNING: begin
                    if (ovr_change || ext_stop) begin
                        state <= ST_LOCKED;
                    end else if (!req.run || !freq_valid) begin
                        state <= ST_STOPPED;
                    end
                end
                ST_LOCKED: begin
                    if (req.run && !req_prev) begin
                        state <= freq_valid ? ST_RUNNING : ST_STOPPED;
                    end else if (!req.run) begin
                        state <= ST_STOPPED;
                    end
                end
                default: state <= ST_STOPPED;
            endcase
        end
    end

    // ==========================================================
    // registered outputs
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            run_out         <= 1'b0;
            reverse_out     <= 1'b0;
            freq_source_sel <= FREQ_CONFIGURED;
            trip_clear      <= 1'b0;
        end else begin
            // the stop causes are gated here too, so run drops one cycle after the cause
            run_out     <= (state == ST_RUNNING) && req.run && freq_valid && !ovr_change && !ext_stop;
            reverse_out <= req.reverse;
            if (key_ovr) begin
                freq_source_sel <= FREQ_KEYPAD;
            end else if (term_ovr) begin
                freq_source_sel <= FREQ_TERMINAL;
            end else begin
                freq_source_sel <= FREQ_CONFIGURED;
            end
            // a muted stop key clears no trip either
            trip_clear <= stop_press && tripped && key_resets;
        end
    end
endmodule // rcs_run_select
`default_nettype wire

/* File: sim/rcs_run_select_chk.sv */
/*
 * rcs_run_select_chk: port-level assertions for the run source selector.
 * assumes one clock sys_clk and synchronous active-high reset.
 */
`timescale 1ns/10ps
`default_nettype none
module rcs_run_select_chk
    import rcs_pkg::*;
#(
    parameter int NTERM = NUM_TERMINALS
) (
    input wire logic             sys_clk,           // control clock
    input wire logic             reset,             // sync reset
    input wire logic [7:0]       run_source_select, // run source
    input wire logic [7:0]       stop_key_enable,   // stop key policy
    input wire logic [NTERM-1:0] terminal_in,       // terminal pins
    input wire logic             keypad_run_key,    // keypad run key
    input wire rcs_cmd_t         serial_cmd,        // serial request
    input wire rcs_cmd_t         option_cmd,        // option request
    input wire logic             freq_valid,        // frequency present
    input wire logic             tripped,           // trip state
    input wire logic             run_out,           // run command
    input wire logic [1:0]       freq_source_sel,   // frequency source
    input wire logic             trip_clear         // trip clear pulse
);
    // ==========================================================
    // quiet time: no terminal pins, no run key, no option request, no source change
    logic [2:0] idle;
    always_ff @(posedge sys_clk) begin
        if (reset || terminal_in != '0 || keypad_run_key || option_cmd.run || $changed(run_source_select)) begin
            idle <= 3'h0;
        end else if (idle != 3'h7) begin
            idle <= idle + 3'h1;
        end
    end
    // ==========================================================
    // assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    property p_rst; $fell(reset) |-> !run_out && !trip_clear && freq_source_sel == 2'h0; endproperty
    a_rst: assert property (p_rst) else $error("outputs not clear after reset");
    property p_nofreq; (!freq_valid) [*3] |-> !run_out; endproperty
    a_nofreq: assert property (p_nofreq) else $error("run without frequency");
    property p_rise; $rose(run_out) |-> $past(freq_valid, 2); endproperty
    a_rise: assert property (p_rise) else $error("run rose without frequency");
    property p_opt; idle == 3'h7 && run_source_select == SRC_OPTION |-> !run_out; endproperty
    a_opt: assert property (p_opt) else $error("option source ran without option request");
    property p_keep;
        idle == 3'h7 && run_source_select == SRC_SERIAL && stop_key_enable != STOPKEY_ALWAYS && run_out
        && serial_cmd.run && freq_valid && $past(serial_cmd.run) && $past(freq_valid) |=> run_out;
    endproperty
    a_keep: assert property (p_keep) else $error("disabled stop key stopped run");
    property p_clr; trip_clear |=> !trip_clear; endproperty
    a_clr: assert property (p_clr) else $error("trip clear longer than one cycle");
    property p_clr_trip; trip_clear |-> $past(tripped); endproperty
    a_clr_trip: assert property (p_clr_trip) else $error("trip clear without trip");
    property p_fcfg; idle == 3'h7 |-> freq_source_sel == FREQ_CONFIGURED; endproperty
    a_fcfg: assert property (p_fcfg) else $error("frequency source overridden without input");
endmodule // rcs_run_select_chk
bind rcs_run_select rcs_run_select_chk #(.NTERM(NTERM)) rcs_run_select_chk_inst (
    .sys_clk(sys_clk), .reset(reset), .run_source_select(run_source_select),
    .stop_key_enable(stop_key_enable), .terminal_in(terminal_in), .keypad_run_key(keypad_run_key),
    .serial_cmd(serial_cmd), .option_cmd(option_cmd), .freq_valid(freq_valid), .tripped(tripped),
    .run_out(run_out), .freq_source_sel(freq_source_sel), .trip_clear(trip_clear));
`default_nettype wire

/* File: sim/rcs_src_model.sv */
/*
 * rcs_src_model: serial bus and option board request sources.
 * assumes the bench names the wanted run level and which source carries it.
 */
`timescale 1ns/10ps
`default_nettype none
module rcs_src_model
    import rcs_pkg::*;
(
    input  wire logic   sys_clk,    // control clock
    input  wire logic   reset,      // sync reset
    input  wire logic   want_run,   // requested run level
    input  wire logic   to_option,  // carry request on option board
    output var rcs_cmd_t serial_cmd, // serial bus request
    output var rcs_cmd_t option_cmd  // option board request
);
    logic flip;
    // ==========================================================
    // the idle source asks stop but wiggles direction, so a stale value never helps
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            flip       <= 1'b0;
            serial_cmd <= '0;
            option_cmd <= '0;
        end else begin
            flip       <= ~flip;
            serial_cmd <= to_option ? {1'b0, flip} : {want_run, 1'b0};
            option_cmd <= to_option ? {want_run, 1'b0} : {1'b0, flip};
        end
    end
endmodule // rcs_src_model
`default_nettype wire

/* File: sim/rcs_run_select_tb.sv */
/*
 * rcs_run_select_tb: self-checking bench for the run source selector.
 * assumes rcs_pkg, the design, the source model and the bound checker.
 */
`timescale 1ns/10ps
`default_nettype none
module rcs_run_select_tb;
    import rcs_pkg::*;
    logic                          sys_clk = 1'b0;
    logic                          reset   = 1'b1;
    logic [7:0]                    src     = SRC_SERIAL;
    logic [7:0]                    skey    = STOPKEY_ALWAYS;
    logic [NUM_TERMINALS*8-1:0]    fn      = {NUM_TERMINALS{8'hff}};
    logic [NUM_TERMINALS-1:0]      term    = '0;
    logic                          krun = 1'b0, kstop = 1'b0, freq = 1'b1, trip = 1'b0, want = 1'b0, to_opt = 1'b0;
    rcs_cmd_t                      ser, opt;
    logic                          run_out, reverse_out, trip_clear;
    logic [1:0]                    fsel;
    int                            failures = 0, tests_run = 0, cyc = 0, clr_n = 0;
    // rows: source code, carried on option, expected run
    logic [9:0]                    rows [7] = '{{SRC_SERIAL, 2'b01}, {SRC_SERIAL, 2'b10}, {SRC_OPTION, 2'b11},
        {SRC_OPTION, 2'b00}, {SRC_KEYPAD, 2'b00}, {SRC_TERMINAL, 2'b00}, {8'h05, 2'b10}};
    always #5 sys_clk = ~sys_clk;
    rcs_src_model rcs_src_model_inst (.sys_clk(sys_clk), .reset(reset), .want_run(want), .to_option(to_opt),
        .serial_cmd(ser), .option_cmd(opt));
    rcs_run_select #(.NTERM(NUM_TERMINALS)) rcs_run_select_inst (.sys_clk(sys_clk), .reset(reset),
        .run_source_select(src), .stop_key_enable(skey), .input_function_assign(fn), .terminal_in(term),
        .keypad_run_key(krun), .keypad_stop_key(kstop), .serial_cmd(ser), .option_cmd(opt), .freq_valid(freq),
        .tripped(trip), .run_out(run_out), .reverse_out(reverse_out), .freq_source_sel(fsel),
        .trip_clear(trip_clear));
    // ==========================================================
    // helpers
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic chk(input string nm, input logic [1:0] e, input logic [1:0] g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // key is held past the two sync stages before release
    task automatic press();
        kstop <= 1'b1;
        step(4);
        kstop <= 1'b0;
        step(3);
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (trip_clear === 1'b1) clr_n <= clr_n + 1;
        if (cyc == 1000) begin
            failures++;
            print_verdict();
        end
    end
    // ==========================================================
    // sequence
    initial begin
        step(5);
        reset <= 1'b0;
        step(2);
        for (int i = 0; i < 7; i++) begin
            src    <= rows[i][9:2];
            to_opt <= rows[i][1];
            want   <= 1'b0;
            step(3);
            want <= 1'b1;
            step(6);
            chk("run_out", {1'b0, rows[i][0]}, {1'b0, run_out});
        end
        $display("source table done");
        src    <= SRC_SERIAL;
        to_opt <= 1'b0;
        freq   <= 1'b0;
        step(6);
        chk("no_freq", 2'h0, {1'b0, run_out});
        freq <= 1'b1;
        step(5);
        chk("freq_run", 2'h1, {1'b0, run_out});
        press();
        chk("stop_always", 2'h0, {1'b0, run_out});
        step(5);
        chk("held_locked", 2'h0, {1'b0, run_out});
        want <= 1'b0;
        step(2);
        want <= 1'b1;
        step(5);
        chk("rearm", 2'h1, {1'b0, run_out});
        skey <= STOPKEY_DISABLE;
        trip <= 1'b1;
        press();
        chk("stop_ignored", 2'h1, {1'b0, run_out});
        skey <= STOPKEY_TRIP_ONLY;
        press();
        chk("trip_run", 2'h1, {1'b0, run_out});
        trip <= 1'b0;
        press();
        chk("trip_only_run", 2'h1, {1'b0, run_out});
        chk("clear_pulses", 2'h1, clr_n[1:0]);
        $display("stop key done");
        want <= 1'b0;
        src  <= SRC_TERMINAL;
        term <= '1;
        step(6);
        chk("unassigned_run", 2'h0, {1'b0, run_out});
        chk("unassigned_fsel", FREQ_CONFIGURED, fsel);
        fn   <= {{5{8'hff}}, FN_TERM_OVR, FN_KEY_OVR};
        term <= 7'h01;
        step(6);
        chk("fsel_key", FREQ_KEYPAD, fsel);
        term <= 7'h03;
        step(6);
        chk("both_ovr", FREQ_KEYPAD, fsel);
        term <= 7'h02;
        step(6);
        chk("fsel_term", FREQ_TERMINAL, fsel);
        term <= 7'h01;
        step(6);
        krun <= 1'b1;
        step(4);
        krun <= 1'b0;
        step(3);
        chk("key_run", 2'h1, {1'b0, run_out});
        term <= 7'h00;
        step(6);
        chk("ovr_drop", 2'h0, {1'b0, run_out});
        fn   <= {{5{8'hff}}, FN_REVERSE, FN_FORWARD};
        term <= 7'h03;
        step(8);
        chk("fw_rv", 2'h0, {1'b0, run_out});
        term <= 7'h01;
        step(8);
        chk("fw_only", 2'h2, {run_out, reverse_out});
        term <= 7'h02;
        step(6);
        chk("rv_only", 2'h3, {run_out, reverse_out});
        $display("override and terminal done");
        // mid-run reset clears the outputs; a held terminal run level resumes after it
        reset <= 1'b1;
        step(2);
        chk("rst_run", 2'h0, {run_out, reverse_out});
        chk("rst_fsel", FREQ_CONFIGURED, fsel);
        reset <= 1'b0;
        step(6);
        chk("rst_resume", 2'h3, {run_out, reverse_out});
        $display("mid-run reset done");
        fn   <= {{4{8'hff}}, FN_DIR3, FN_STP, FN_STA};
        term <= 7'h02;
        step(6);
        chk("three_idle", 2'h0, {1'b0, run_out});
        term <= 7'h07;
        step(3);
        term <= 7'h06;
        step(4);
        chk("three_start", 2'h3, {run_out, reverse_out});
        term <= 7'h00;
        step(6);
        chk("three_stop", 2'h0, {1'b0, run_out});
        $display("three-wire done");
        src  <= SRC_SERIAL;
        want <= 1'b1;
        fn   <= {{5{8'hff}}, FN_TERM_OVR, FN_FORWARD};
        step(6);
        chk("ser_run", 2'h1, {1'b0, run_out});
        term <= 7'h03;
        step(6);
        chk("ovr_lock", 2'h0, {1'b0, run_out});
        term <= 7'h02;
        step(4);
        term <= 7'h03;
        step(6);
        chk("ovr_rearm", 2'h1, {1'b0, run_out});
        $display("override lock done");
        print_verdict();
    end
endmodule // rcs_run_select_tb
`default_nettype wire
